// ===== hw/ssp_pkg.sv
/*
 * shared constants and carriers for the stage servo pulse drive.
 * assumes a single 200 MHz clock and synchronous active-low reset.
 */
package ssp_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 200_000_000;
	localparam int WIND_HZ      = 400;
	// phase clock runs at four ticks per winding cycle
	localparam int QUARTER_CYC  = CLK_HZ / (WIND_HZ * 4);
	localparam int ERR_W        = 8;
	localparam int ERR_FULL     = 127;
	localparam int POS_W        = 24;
	localparam int RAMP_W       = 8;
	localparam int HALF_CYC     = QUARTER_CYC * 2;
	localparam int RAMP_DIV     = HALF_CYC / (ERR_FULL + 1);
	localparam int RST_PULSE_W  = 1;

	// ------------------------------------------------------------
	// quadrature phase set
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SSP_Q0,
		SSP_Q90,
		SSP_Q180,
		SSP_Q270
	} ssp_quad_e;

	typedef struct packed {
		logic ref_ph;
		logic ref_inv;
		logic sh_ph;
		logic sh_inv;
	} ssp_phase_s;

	typedef struct packed {
		logic clockwise_drive;
		logic ccw_drive;
	} ssp_dir_s;

	typedef struct packed {
		logic push_a;
		logic pull_a;
		logic push_b;
		logic pull_b;
	} ssp_wind_s;

	typedef enum logic [1:0] {
		SSP_SRC_HANDWHEEL,
		SSP_SRC_BALL,
		SSP_SRC_TRACK
	} ssp_src_e;

endpackage

// ===== hw/ssp_ctrl_gen.sv
/*
 * control generator: signed error to clockwise/counterclockwise pulse.
 * assumes reset_pulse from the phase clock at 90 and 270 degrees.
 */
`timescale 1ns/1ps
module ssp_ctrl_gen #(
	parameter int ERR_W    = ssp_pkg::ERR_W,
	parameter int RAMP_DIV = ssp_pkg::RAMP_DIV
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    reset_pulse,
	input  wire logic signed [ERR_W-1:0] err,
	output ssp_pkg::ssp_dir_s            dir
);
	import ssp_pkg::*;

	logic [ERR_W-1:0] ramp_q;
	logic [31:0]      div_q;
	logic             tick;
	logic [ERR_W-1:0] mag;
	logic             neg;
	logic             act_q;
	logic             neg_q;
	ssp_dir_s         dir_q;

	// ------------------------------------------------------------
	// ramp
	// ------------------------------------------------------------
	assign tick = (div_q == 32'(RAMP_DIV - 1));
	assign neg  = err[ERR_W-1];
	// magnitude; most negative saturates to full scale
	assign mag  = neg ? ((err == {1'b1, {(ERR_W-1){1'b0}}}) ?
		{1'b0, {(ERR_W-1){1'b1}}} : ERR_W'(-err)) : err;

	always_ff @(posedge clk) begin
		if (!rst_b || reset_pulse || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 32'd1;
		end
	end

	// restart ramp at each reset pulse
	always_ff @(posedge clk) begin
		if (!rst_b || reset_pulse) begin
			ramp_q <= '0;
		end else if (tick && !(&ramp_q)) begin
			ramp_q <= ramp_q + 1'b1;
		end
	end

	// one rising ramp compares the magnitude for both signs
	// sign picks direction, width follows magnitude
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			act_q <= 1'b0;
			neg_q <= 1'b0;
		end else if (reset_pulse) begin
			act_q <= (mag != '0);
			neg_q <= neg;
		end else if (ramp_q >= mag) begin
			act_q <= 1'b0;
		end
	end

	// at most one high by construction: only one sign latched
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dir_q <= '0;
		end else begin
			dir_q.clockwise_drive <= act_q && !neg_q;
			dir_q.ccw_drive       <= act_q && neg_q;
		end
	end

	assign dir = dir_q;

endmodule

// ===== hw/ssp_axis.sv
/*
 * one axis of the stage servo pulse drive: phase clock, control
 * generator(s), direction logic, error source select, position counter.
 * assumes encoder pins are asynchronous; all else on clk.
 */
// Notes on behaviour
// - four phases: 0, inverse, 90, inverse
// - phase clock at 400 Hz winding rate
// - reset pulse at 90 and 270 degrees
// - error sign is direction, magnitude speed
// - reset restarts true and inverted ramps (code restarts its single rising ramp only)
// - output high from reset until ramp reaches
// - clockwise and counterclockwise never together
// - speed set only by drive duty cycle
// - pulses gate reference or shifted pair
// - push-pull outputs carry duty unchanged
// - standard: reference winding straight from clock
// - alternative: reference modulated, two generators
// - quadrature encoder decides up or down
// - coordinate read from readout register
// - equal counts up and down per travel
// - return within two counts is accurate
// - joystick disconnects other error sources
`timescale 1ns/1ps
module ssp_axis #(
	parameter int  QUARTER_CYC = ssp_pkg::QUARTER_CYC,
	parameter int  RAMP_DIV    = ssp_pkg::RAMP_DIV,
	parameter int  ERR_W       = ssp_pkg::ERR_W,
	parameter int  POS_W       = ssp_pkg::POS_W,
	parameter bit  ALT_VARIANT = 1'b0
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    joystick_active,
	input  wire logic signed [ERR_W-1:0] joystick_err,
	input  wire logic signed [ERR_W-1:0] aux_err,
	input  wire logic                    readout_load,
	input  wire logic                    enc_a,
	input  wire logic                    enc_b,
	output ssp_pkg::ssp_phase_s          phase,
	output logic                         reset_pulse,
	output ssp_pkg::ssp_dir_s            dir,
	output ssp_pkg::ssp_wind_s           control_wind,
	output ssp_pkg::ssp_wind_s           ref_wind,
	output logic [POS_W-1:0]             coord,
	output logic [POS_W-1:0]             live_count
);
	import ssp_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// quadrants step 0, 90, 180, 270 and wrap
	function automatic ssp_quad_e next_quad(input ssp_quad_e q);
		case (q)
			SSP_Q0:   return SSP_Q90;
			SSP_Q90:  return SSP_Q180;
			SSP_Q180: return SSP_Q270;
			default:  return SSP_Q0;
		endcase
	endfunction

	// a square wave is high in two named quadrants
	function automatic logic quad_high(input ssp_quad_e q,
		input ssp_quad_e hi_a, input ssp_quad_e hi_b);
		return (q == hi_a) || (q == hi_b);
	endfunction

	// hold the last level until stages two and three agree, so a
	// metastable first stage never reaches the decoder
	function automatic logic sync_pick(input logic [2:0] sy,
		input logic held);
		return (sy[1] == sy[2]) ? sy[2] : held;
	endfunction

	// ------------------------------------------------------------
	// phase clock
	// ------------------------------------------------------------
	logic [31:0]  qdiv_q;
	ssp_quad_e    quad_q;
	logic         qtick;
	logic         ref_hi;
	logic         sh_hi;
	logic         half_start;
	logic         rst_pulse_q;
	ssp_phase_s   phase_q;

	assign qtick = (qdiv_q == 32'(QUARTER_CYC - 1));

	always_ff @(posedge clk) begin
		if (!rst_b || qtick) begin
			qdiv_q <= '0;
		end else begin
			qdiv_q <= qdiv_q + 32'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			quad_q <= SSP_Q0;
		end else if (qtick) begin
			quad_q <= next_quad(quad_q);
		end
	end

	// reference high 0..180, shifted pair lags by a quarter
	assign ref_hi     = quad_high(quad_q, SSP_Q0, SSP_Q90);
	assign sh_hi      = quad_high(quad_q, SSP_Q90, SSP_Q180);
	// leaving 0 or 180 is entering 90 or 270
	assign half_start = qtick && quad_high(quad_q, SSP_Q0, SSP_Q180);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_q <= '0;
		end else begin
			phase_q.ref_ph  <= ref_hi;
			phase_q.ref_inv <= !ref_hi;
			phase_q.sh_ph   <= sh_hi;
			phase_q.sh_inv  <= !sh_hi;
		end
	end

	// entering 90 or 270 degrees; one clock wide
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rst_pulse_q <= 1'b0;
		end else begin
			rst_pulse_q <= half_start;
		end
	end

	assign phase       = phase_q;
	assign reset_pulse = rst_pulse_q;

	// ------------------------------------------------------------
	// error source select
	// ------------------------------------------------------------
	logic signed [ERR_W-1:0] err_sel;
	logic signed [ERR_W-1:0] err_q;

	// joystick cuts out handwheel and ball sources
	assign err_sel = joystick_active ? joystick_err : aux_err;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_q <= '0;
		end else begin
			err_q <= err_sel;
		end
	end

	// ------------------------------------------------------------
	// control generators
	// ------------------------------------------------------------
	ssp_dir_s dir_ctl;
	ssp_dir_s dir_ref;

	ssp_ctrl_gen #(
		.ERR_W    (ERR_W),
		.RAMP_DIV (RAMP_DIV)
	) u_gen_ctl (
		.clk         (clk),
		.rst_b       (rst_b),
		.reset_pulse (rst_pulse_q),
		.err         (err_q),
		.dir         (dir_ctl)
	);

	// second generator only in the alternative variant
	generate
		if (ALT_VARIANT) begin : g_alt
			ssp_ctrl_gen #(
				.ERR_W    (ERR_W),
				.RAMP_DIV (RAMP_DIV)
			) u_gen_ref (
				.clk         (clk),
				.rst_b       (rst_b),
				.reset_pulse (rst_pulse_q),
				.err         (err_q),
				.dir         (dir_ref)
			);
		end else begin : g_std
			assign dir_ref = '0;
		end
	endgenerate

	assign dir = dir_ctl;

	// ------------------------------------------------------------
	// direction logic
	// ------------------------------------------------------------
	// cw gates reference pair, ccw gates shifted pair, so the control
	// winding leads or lags; duty from the generator passes unchanged
	logic      cw_on;
	logic      ccw_on;
	logic      any_on;
	logic      src_a;
	logic      src_b;
	ssp_wind_s cw_q;
	ssp_wind_s rw_q;

	assign cw_on  = dir_ctl.clockwise_drive;
	assign ccw_on = dir_ctl.ccw_drive;
	assign any_on = cw_on || ccw_on;
	assign src_a  = cw_on ? phase_q.ref_ph : phase_q.sh_ph;
	assign src_b  = cw_on ? phase_q.ref_inv : phase_q.sh_inv;

	// push-pull pair, both low when idle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cw_q <= '0;
		end else begin
			cw_q.push_a <= any_on && src_a;
			cw_q.pull_a <= any_on && !src_a;
			cw_q.push_b <= any_on && src_b;
			cw_q.pull_b <= any_on && !src_b;
		end
	end

	logic ref_gate;
	assign ref_gate = ALT_VARIANT ?
		(dir_ref.clockwise_drive || dir_ref.ccw_drive) : 1'b1;

	// standard: reference winding straight from the clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rw_q <= '0;
		end else begin
			rw_q.push_a <= ref_gate && phase_q.ref_ph;
			rw_q.pull_a <= ref_gate && !phase_q.ref_ph;
			rw_q.push_b <= ref_gate && phase_q.ref_inv;
			rw_q.pull_b <= ref_gate && !phase_q.ref_inv;
		end
	end

	assign control_wind = cw_q;
	assign ref_wind     = rw_q;

	// ------------------------------------------------------------
	// encoder input and position counter
	// ------------------------------------------------------------
	logic [2:0]       a_sy_q;
	logic [2:0]       b_sy_q;
	logic             a_q;
	logic             b_q;
	logic             a_new;
	logic             b_new;
	logic             a_chg;
	logic             b_chg;
	logic             step;
	logic             up;
	logic [POS_W-1:0] cnt_q;
	logic [POS_W-1:0] coord_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			a_sy_q <= '0;
			b_sy_q <= '0;
		end else begin
			a_sy_q <= {a_sy_q[1:0], enc_a};
			b_sy_q <= {b_sy_q[1:0], enc_b};
		end
	end

	// accept a level only once stages two and three agree
	assign a_new = sync_pick(a_sy_q, a_q);
	assign b_new = sync_pick(b_sy_q, b_q);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= a_new;
			b_q <= b_new;
		end
	end

	// full x4 decode: every single-pin edge counts, symmetric both ways
	assign a_chg = (a_new != a_q);
	assign b_chg = (b_new != b_q);
	assign step  = a_chg ^ b_chg;
	assign up    = a_chg ? (a_new != b_q) : (b_new == a_q);

	// a double edge is dropped rather than guessed; keeps drift
	// within the return tolerance
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (step) begin
			cnt_q <= up ? cnt_q + 1'b1 : cnt_q - 1'b1;
		end
	end

	// coordinate comes from readout register, not counter
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			coord_q <= '0;
		end else if (readout_load) begin
			coord_q <= cnt_q;
		end
	end

	assign coord      = coord_q;
	assign live_count = cnt_q;

endmodule

// ===== verification/ssp_axis_chk.sv
/* port assertions for ssp_axis.
   assumes one clk and sync active-low reset. */
`timescale 1ns/1ps
module ssp_axis_chk
	import ssp_pkg::*;
#(
	parameter int QUARTER_CYC = 40
) (
	input wire logic                    clk,
	input wire logic                    rst_b,
	input wire logic                    joystick_active,
	input wire logic signed [ERR_W-1:0] joystick_err,
	input wire logic signed [ERR_W-1:0] aux_err,
	input wire logic                    readout_load,
	input ssp_phase_s                   phase,
	input wire logic                    reset_pulse,
	input ssp_dir_s                     dir,
	input ssp_wind_s                    control_wind,
	input wire logic [POS_W-1:0]        coord,
	input wire logic [POS_W-1:0]        live_count
);
	// ----
	// helpers
	// ----
	logic signed [ERR_W-1:0] sel;
	logic [1:0]              up_q;
	logic                    seen_q;
	logic [31:0]             gap_q;
	assign sel = joystick_active ? joystick_err : aux_err;
	// phases settle one edge after release; checks wait for three
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			up_q <= 2'h0;
			seen_q <= 1'b0;
			gap_q <= 32'h0000_0000;
		end else begin
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
			seen_q <= seen_q | reset_pulse;
			gap_q <= reset_pulse ? 32'h0000_0000 :
				gap_q + 32'h0000_0001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----
	// properties
	// ----
	dir_excl_a: assert property (
		!(dir.clockwise_drive && dir.ccw_drive)) else $error("both dirs");
	phase_inv_a: assert property (
		up_q == 2'h3 |-> phase.ref_inv != phase.ref_ph &&
		phase.sh_inv != phase.sh_ph) else $error("phase inverse");
	pulse_gap_a: assert property (
		reset_pulse && seen_q |-> gap_q == 32'(2 * QUARTER_CYC - 1))
		else $error("pulse spacing");
	cw_start_a: assert property (
		reset_pulse && sel > 0 && $past(sel) == sel |->
		##2 dir.clockwise_drive) else $error("no cw pulse");
	ccw_start_a: assert property (
		reset_pulse && sel < 0 && $past(sel) == sel |->
		##2 dir.ccw_drive) else $error("no ccw pulse");
	zero_err_a: assert property (
		reset_pulse && sel == 0 && $past(sel) == 0 |-> ##2 dir == '0)
		else $error("zero drives");
	idle_wind_a: assert property (
		dir == '0 |=> control_wind == '0) else $error("idle wind");
	load_hold_a: assert property (
		readout_load |=> coord == $past(live_count)) else $error("load");
endmodule
bind ssp_axis ssp_axis_chk #(.QUARTER_CYC(QUARTER_CYC)) u_chk (
	.clk, .rst_b, .joystick_active, .joystick_err, .aux_err,
	.readout_load, .phase, .reset_pulse, .dir, .control_wind,
	.coord, .live_count);

// ===== verification/ssp_enc_model.sv
/* quadrature encoder model.
   assumes the bench calls move between checks. */
`timescale 1ns/1ps
module ssp_enc_model (
	input  wire logic clk,
	output logic      enc_a,
	output logic      enc_b
);
	// ----
	// quadrature state
	// ----
	logic [1:0] pos = 2'h0;
	// gray order, one pin per step, a leads b going up
	assign enc_a = pos[1] ^ pos[0];
	assign enc_b = pos[1];
	// six cycles a step clears the input synchroniser
	task automatic move(input int n, input bit up);
		repeat (n) begin
			repeat (6) @(negedge clk);
			pos = up ? pos + 2'h1 : pos - 2'h1;
		end
	endtask
endmodule

// ===== verification/ssp_axis_tb.sv
/* self-checking bench for ssp_axis.
   assumes short sim counts: quarter 40, ramp step 1. */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
	samples_checked++; \
	if ((s) !== (e)) begin \
		err_total++; \
		$display("wrong value %s exp %0h got %0h", nm, e, s); \
	end \
end
module ssp_axis_tb;
	import ssp_pkg::*;
	// ----
	// harness
	// ----
	localparam int QC = 40;
	logic                    clk = 1'b0;
	logic                    rst_b = 1'b0;
	logic                    joystick_active = 1'b1;
	logic signed [ERR_W-1:0] joystick_err = 8'sh00;
	logic signed [ERR_W-1:0] aux_err = 8'sh00;
	logic                    readout_load = 1'b0;
	logic                    enc_a;
	logic                    enc_b;
	ssp_phase_s              phase;
	logic                    reset_pulse;
	ssp_dir_s                dir;
	ssp_wind_s               control_wind;
	ssp_wind_s               ref_wind;
	ssp_wind_s               ref_wind_alt;
	logic [POS_W-1:0]        coord;
	logic [POS_W-1:0]        live_count;
	int                      err_total = 0;
	int                      samples_checked = 0;
	int                      cyc = 0;
	int                      wc;
	int                      wn;
	int                      ww;
	int                      wa;
	int                      wr;
	always #2.5 clk = ~clk;
	ssp_axis #(.QUARTER_CYC(QC), .RAMP_DIV(1)) DUT (
		.clk, .rst_b, .joystick_active, .joystick_err, .aux_err,
		.readout_load, .enc_a, .enc_b, .phase, .reset_pulse, .dir,
		.control_wind, .ref_wind, .coord, .live_count);
	// second instance in the variant with a modulated reference
	ssp_axis #(.QUARTER_CYC(QC), .RAMP_DIV(1), .ALT_VARIANT(1'b1))
		DUT_ALT (
		.clk, .rst_b, .joystick_active, .joystick_err, .aux_err,
		.readout_load, .enc_a, .enc_b, .phase(), .reset_pulse(),
		.dir(), .control_wind(), .ref_wind(ref_wind_alt), .coord(),
		.live_count());
	ssp_enc_model enc (.clk, .enc_a, .enc_b);
	// ----
	// tasks
	// ----
	task automatic summarize;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// second pulse: first half may still use the old value
	task automatic run_err(input logic a, input logic [7:0] j, k);
		@(negedge clk);
		joystick_active = a;
		joystick_err = j;
		aux_err = k;
		repeat (2) begin
			@(negedge clk);
			for (int i = 0; i < 400 && reset_pulse !== 1'b1; i++)
				@(negedge clk);
		end
		{wc, wn, ww, wa, wr} = '0;
		repeat (2 * QC) begin
			@(negedge clk);
			wc += dir.clockwise_drive;
			wn += dir.ccw_drive;
			ww += (control_wind != '0);
			wa += (ref_wind_alt != '0);
			// shifted pair differs from reference past a quarter
			wr += (control_wind != '0 &&
				control_wind.push_a != phase.ref_ph);
		end
	endtask
	task automatic t_phase;
		int hi = 0, both = 0, rp = 0, rz = 0;
		repeat (4 * QC) begin
			@(negedge clk);
			hi += phase.ref_ph;
			both += phase.ref_ph & phase.sh_ph;
			rp += reset_pulse;
			rz += (ref_wind == '0);
		end
		`CHK("ref high", 2 * QC, hi)
		`CHK("overlap", QC, both)
		`CHK("pulses", 2, rp)
		`CHK("ref wind", 0, rz)
	endtask
	task automatic t_dir;
		run_err(1'b1, 8'h0A, 8'h00);
		`CHK("cw 10", 1'b1, wc inside {[10:13]})
		`CHK("wind duty", wc, ww)
		`CHK("alt ref on", 1'b1, wa inside {[10:13]})
		run_err(1'b1, 8'h1E, 8'h00);
		`CHK("cw 30", 1'b1, wc inside {[30:33]})
		`CHK("ccw off", 0, wn)
		run_err(1'b1, 8'hEC, 8'h00);
		`CHK("ccw 20", 1'b1, wn inside {[20:23]})
		`CHK("cw off", 0, wc)
		run_err(1'b1, 8'h00, 8'h00);
		`CHK("zero", 0, wc + wn + ww)
		`CHK("alt ref idle", 0, wa)
		run_err(1'b1, 8'h3C, 8'h00);
		`CHK("cw 60", 1'b1, wc inside {[60:63]})
		`CHK("cw gating", 1, wr)
		run_err(1'b1, 8'hC4, 8'h00);
		`CHK("ccw 60", 1'b1, wn inside {[60:63]})
		`CHK("ccw gating", 1'b1, wr inside {[21:25]})
	endtask
	task automatic t_sel;
		run_err(1'b0, 8'h1E, 8'h00);
		`CHK("joy off", 0, wc + wn)
		run_err(1'b0, 8'h00, 8'hFB);
		`CHK("aux ccw", 1'b1, wn inside {[5:8]})
		run_err(1'b1, 8'h00, 8'hFB);
		`CHK("aux cut", 0, wc + wn)
	endtask
	task automatic t_enc;
		enc.move(7, 1'b1);
		repeat (10) @(negedge clk);
		`CHK("count up", 24'h00_0007, live_count)
		`CHK("coord held", 24'h00_0000, coord)
		readout_load = 1'b1;
		@(negedge clk);
		readout_load = 1'b0;
		`CHK("coord load", 24'h00_0007, coord)
		enc.move(7, 1'b0);
		repeat (10) @(negedge clk);
		`CHK("return", 24'h00_0000, live_count)
	endtask
	// ----
	// sequence
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		t_phase();
		t_dir();
		t_sel();
		t_enc();
		summarize();
	end
endmodule
